/* src/irq_mux_pkg.sv */
package irq_mux_pkg;

	// register map, 8-bit i/o space of the card
	localparam logic [7:0] SRC_SEL_OFFSET = 8'h20;
	localparam logic [7:0] CLEAR_OFFSET = 8'h30;

	// field positions inside the source-select byte
	localparam int CH1_SEL_LSB = 0;
	localparam int CH2_SEL_LSB = 2;
	localparam int SEL_WIDTH = 4;

	// field positions inside the clear-request byte
	localparam int CLR_CH1_BIT = 0;
	localparam int CLR_CH2_BIT = 1;

	// value of the source-select bits after any reset
	localparam logic [3:0] SRC_SEL_RESET = 4'h0;

	// sampled pin positions on the synchroniser
	localparam int PIN_G1_L0 = 0;
	localparam int PIN_G1_L3 = 1;
	localparam int PIN_G1_L4 = 2;
	localparam int PIN_G2_L0 = 3;
	localparam int PIN_G2_L3 = 4;
	localparam int PIN_EVT = 5;
	localparam int PIN_TMR = 6;
	localparam int PIN_COUNT = 7;

	// reset value of every sampled pin (idle high, as on the pulled-up port)
	localparam logic [6:0] PIN_IDLE = 7'h7f;

	// per-channel source encodings
	typedef enum logic [1:0] {
		SRC_OFF = 2'b00,
		SRC_FALL = 2'b01,
		SRC_COMB = 2'b10,
		SRC_COUNT = 2'b11
	} irq_src_t;

endpackage

/* src/pin_sync_edge.sv */
// two-stage synchroniser with edge detect on the settled copy
module pin_sync_edge
	import irq_mux_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// raw pins
	input wire logic [PIN_COUNT-1:0] i_pins,
	// settled level and one-cycle edges
	output logic [PIN_COUNT-1:0] o_level,
	output logic [PIN_COUNT-1:0] o_rise,
	output logic [PIN_COUNT-1:0] o_fall
);

	logic [PIN_COUNT-1:0] meta_reg;
	logic [PIN_COUNT-1:0] level_reg;
	logic [PIN_COUNT-1:0] prev_reg;

	// the first stage feeds only the second; edges compare stages two and three
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_pin
			always_ff @(posedge i_core_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					meta_reg[g] <= PIN_IDLE[g];
					level_reg[g] <= PIN_IDLE[g];
					prev_reg[g] <= PIN_IDLE[g];
				end else begin
					meta_reg[g] <= i_pins[g];
					level_reg[g] <= meta_reg[g];
					prev_reg[g] <= level_reg[g];
				end
			end
			assign o_rise[g] = level_reg[g] & ~prev_reg[g];
			assign o_fall[g] = ~level_reg[g] & prev_reg[g];
		end
	endgenerate

	assign o_level = level_reg;

endmodule // pin_sync_edge

/* src/dual_irq_source_mux.sv */
// How it works
// RULE1: both channels drive one shared active-low interrupt line to the host.
// RULE2: source-select byte at offset 0x20 is write-only; low four bits used.
// RULE3: first channel field 00 disables, 01 triggers on group-1 line 0 falling.
// RULE4: first channel field 11 triggers when the event counter reaches zero.
// RULE5: second channel field 00 off, 01 group-2 line 0 falling, 10 combined.
// RULE6: second channel field 11 triggers when the cascaded timer reaches zero.
// RULE7: combined mode raises nothing while line 0 stays high.
// RULE8: combined mode raises nothing while line 3 stays low.
// RULE9: combined mode triggers on line 3 falling while line 0 is low.
// RULE10: combined mode triggers on line 0 rising while line 3 is high.
// RULE11: host software finds which channel raised the shared line.
// RULE12: host checks the other channel, then clears the serviced one.
// RULE13: event counter is clocked from group-1 control line 4.
// RULE14: cascaded timer output feeds the second channel's timer source.
// RULE15: requests latch on trigger and hold until software clears them.
// RULE16: after reset both fields read disabled, so nothing is requested.
module dual_irq_source_mux
	import irq_mux_pkg::*;
(
	// clock and asynchronous reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// 8-bit i/o write port from the bus interface controller
	input wire logic i_io_wr,
	input wire logic [7:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	// port-c control lines of both groups
	input wire logic i_grp1_ctl_line0,
	input wire logic i_grp1_ctl_line3,
	input wire logic i_grp1_ctl_line4,
	input wire logic i_grp2_ctl_line0,
	input wire logic i_grp2_ctl_line3,
	// counter outputs from the timer block
	input wire logic i_event_count_out,
	input wire logic i_cascade_timer_out,
	// request state and shared interrupt
	output logic o_first_request_channel,
	output logic o_second_request_channel,
	output logic o_inta_n,
	// clock for the event counter
	output logic o_event_counter_clk
);

	// reset release through two flops
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// every pin crosses into the core clock before any decision
	logic [PIN_COUNT-1:0] raw_pins;
	logic [PIN_COUNT-1:0] pin_lvl;
	logic [PIN_COUNT-1:0] pin_rise;
	logic [PIN_COUNT-1:0] pin_fall;

	assign raw_pins[PIN_G1_L0] = i_grp1_ctl_line0;
	assign raw_pins[PIN_G1_L3] = i_grp1_ctl_line3;
	assign raw_pins[PIN_G1_L4] = i_grp1_ctl_line4;
	assign raw_pins[PIN_G2_L0] = i_grp2_ctl_line0;
	assign raw_pins[PIN_G2_L3] = i_grp2_ctl_line3;
	assign raw_pins[PIN_EVT] = i_event_count_out;
	assign raw_pins[PIN_TMR] = i_cascade_timer_out;

	pin_sync_edge u_sync (
		.i_core_clk(i_core_clk),
		.i_resetn(rst_n_reg),
		.i_pins(raw_pins),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// trigger decode shared by both channels
	function automatic logic chan_trigger(
		input irq_src_t sel,
		input logic l0_lvl,
		input logic l0_rise,
		input logic l0_fall,
		input logic l3_lvl,
		input logic l3_fall,
		input logic count_evt
	);
		logic hit;
		hit = 1'b0;
		case (sel)
			SRC_OFF: hit = 1'b0;
			SRC_FALL: hit = l0_fall;
			// combined: line 0 staying high or line 3 staying low blocks everything
			SRC_COMB: hit = (l3_fall & ~l0_lvl) // RULE7 RULE9
				| (l0_rise & l3_lvl); // RULE8 RULE10
			SRC_COUNT: hit = count_evt;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// register decode
	logic sel_wr;
	logic clr_wr;

	assign sel_wr = i_io_wr && (i_io_addr == SRC_SEL_OFFSET); // RULE2
	assign clr_wr = i_io_wr && (i_io_addr == CLEAR_OFFSET);

	// source-select and request state
	logic [SEL_WIDTH-1:0] src_sel_reg;
	logic [SEL_WIDTH-1:0] src_sel_next;
	logic req1_reg;
	logic req1_next;
	logic req2_reg;
	logic req2_next;
	logic inta_n_reg;
	logic inta_n_next;
	logic cnt_clk_reg;
	logic cnt_clk_next;
	logic trig1;
	logic trig2;
	irq_src_t sel1;
	irq_src_t sel2;

	assign sel1 = irq_src_t'(src_sel_reg[CH1_SEL_LSB +: 2]);
	assign sel2 = irq_src_t'(src_sel_reg[CH2_SEL_LSB +: 2]);

	// event counter on group 1 line 0/3, timer on group 2 line 0/3
	assign trig1 = chan_trigger(sel1, pin_lvl[PIN_G1_L0], pin_rise[PIN_G1_L0], // RULE3
		pin_fall[PIN_G1_L0], pin_lvl[PIN_G1_L3], pin_fall[PIN_G1_L3],
		pin_rise[PIN_EVT]); // RULE4
	// the timer pulses low at its zero count, so its falling edge is the event
	assign trig2 = chan_trigger(sel2, pin_lvl[PIN_G2_L0], pin_rise[PIN_G2_L0], // RULE5
		pin_fall[PIN_G2_L0], pin_lvl[PIN_G2_L3], pin_fall[PIN_G2_L3],
		pin_fall[PIN_TMR]); // RULE6 RULE14

	// next-state: select byte, sticky requests, shared line
	always_comb begin
		src_sel_next = src_sel_reg;
		if (sel_wr) begin
			src_sel_next = i_io_wdata[SEL_WIDTH-1:0]; // RULE2
		end
		// set wins over a clear arriving in the same cycle, so no event is lost
		req1_next = req1_reg;
		if (clr_wr && i_io_wdata[CLR_CH1_BIT]) begin
			req1_next = 1'b0; // RULE15
		end
		if (trig1) begin
			req1_next = 1'b1; // RULE15
		end
		req2_next = req2_reg;
		if (clr_wr && i_io_wdata[CLR_CH2_BIT]) begin
			req2_next = 1'b0;
		end
		if (trig2) begin
			req2_next = 1'b1;
		end
		inta_n_next = ~(req1_next | req2_next); // RULE1
		cnt_clk_next = pin_lvl[PIN_G1_L4]; // RULE13
	end

	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			src_sel_reg <= SRC_SEL_RESET; // RULE16
			req1_reg <= 1'b0;
			req2_reg <= 1'b0;
			inta_n_reg <= 1'b1;
			cnt_clk_reg <= 1'b1;
		end else begin
			src_sel_reg <= src_sel_next;
			req1_reg <= req1_next;
			req2_reg <= req2_next;
			inta_n_reg <= inta_n_next;
			cnt_clk_reg <= cnt_clk_next;
		end
	end

	// the pending bits let software tell the two channels apart
	assign o_first_request_channel = req1_reg;
	assign o_second_request_channel = req2_reg;
	assign o_inta_n = inta_n_reg;
	assign o_event_counter_clk = cnt_clk_reg;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n_reg);

	shared_line_a: assert property ( // RULE1
		o_inta_n == !(o_first_request_channel || o_second_request_channel))
		else $error("shared line does not follow pending requests");

	sel_write_a: assert property ( // RULE2
		sel_wr |=> src_sel_reg == $past(i_io_wdata[3:0]))
		else $error("source select not loaded from write");

	sel_hold_a: assert property ( // RULE2
		!sel_wr |=> src_sel_reg == $past(src_sel_reg))
		else $error("source select changed without a write");

	ch1_fall_a: assert property ( // RULE3
		sel1 == SRC_FALL && pin_fall[PIN_G1_L0] |=> o_first_request_channel)
		else $error("first channel missed line 0 falling edge");

	ch1_off_a: assert property ( // RULE3
		sel1 == SRC_OFF && !req1_reg |=> !o_first_request_channel)
		else $error("disabled first channel raised a request");

	ch1_edge_only_a: assert property ( // RULE3
		sel1 == SRC_FALL && !pin_fall[PIN_G1_L0] && !req1_reg
		|=> !o_first_request_channel)
		else $error("first channel fired without a falling edge");

	ch1_count_a: assert property ( // RULE4
		sel1 == SRC_COUNT && pin_rise[PIN_EVT] |=> o_first_request_channel)
		else $error("first channel missed event counter zero");

	ch2_fall_a: assert property ( // RULE5
		sel2 == SRC_FALL && $fell(pin_lvl[PIN_G2_L0]) |=> o_second_request_channel)
		else $error("second channel missed line 0 falling edge");

	ch2_off_a: assert property ( // RULE5
		sel2 == SRC_OFF && !req2_reg |=> !o_second_request_channel)
		else $error("disabled second channel raised a request");

	ch2_timer_a: assert property ( // RULE6
		sel2 == SRC_COUNT && pin_fall[PIN_TMR] |=> !o_inta_n)
		else $error("timer zero did not reach shared line");

	comb_line0_a: assert property ( // RULE7
		sel2 == SRC_COMB && pin_lvl[PIN_G2_L0] && !pin_rise[PIN_G2_L0] && !req2_reg
		|=> !o_second_request_channel)
		else $error("combined mode fired with line 0 high");

	comb_line3_a: assert property ( // RULE8
		sel2 == SRC_COMB && !pin_lvl[PIN_G2_L3] && !pin_fall[PIN_G2_L3] && !req2_reg
		|=> !o_second_request_channel)
		else $error("combined mode fired with line 3 low");

	ch1_line0_a: assert property ( // RULE7
		sel1 == SRC_COMB && pin_lvl[PIN_G1_L0] && !pin_rise[PIN_G1_L0] && !req1_reg
		|=> !o_first_request_channel)
		else $error("first channel combined mode fired with line 0 high");

	ch1_line3_a: assert property ( // RULE8
		sel1 == SRC_COMB && !pin_lvl[PIN_G1_L3] && !pin_fall[PIN_G1_L3] && !req1_reg
		|=> !o_first_request_channel)
		else $error("first channel combined mode fired with line 3 low");

	comb_fall3_a: assert property ( // RULE9
		sel1 == SRC_COMB && pin_fall[PIN_G1_L3] && !pin_lvl[PIN_G1_L0]
		|=> o_first_request_channel)
		else $error("combined mode missed line 3 falling edge");

	ch2_fall3_a: assert property ( // RULE9
		sel2 == SRC_COMB && pin_fall[PIN_G2_L3] && !pin_lvl[PIN_G2_L0]
		|=> o_second_request_channel)
		else $error("second channel missed line 3 falling edge");

	comb_rise0_a: assert property ( // RULE10
		sel2 == SRC_COMB && pin_rise[PIN_G2_L0] && pin_lvl[PIN_G2_L3]
		|=> o_second_request_channel)
		else $error("combined mode missed line 0 rising edge");

	ch1_rise0_a: assert property ( // RULE10
		sel1 == SRC_COMB && pin_rise[PIN_G1_L0] && pin_lvl[PIN_G1_L3]
		|=> o_first_request_channel)
		else $error("first channel missed line 0 rising edge");

	comb_both_a: assert property ( // RULE7
		sel2 == SRC_COMB && pin_rise[PIN_G2_L0] && pin_fall[PIN_G2_L3] && !req2_reg
		|=> !o_second_request_channel)
		else $error("combined mode fired on opposing edges");

	req_hold_a: assert property ( // RULE15
		req1_reg && !(clr_wr && i_io_wdata[CLR_CH1_BIT]) |=> req1_reg)
		else $error("first request dropped without a clear");

	req2_hold_a: assert property ( // RULE15
		req2_reg && !(clr_wr && i_io_wdata[CLR_CH2_BIT]) |=> req2_reg)
		else $error("second request dropped without a clear");

	req_clear_a: assert property ( // RULE15
		clr_wr && i_io_wdata[CLR_CH2_BIT] && !trig2 |=> !o_second_request_channel)
		else $error("second request not cleared by software");

	req1_clear_a: assert property ( // RULE15
		clr_wr && i_io_wdata[CLR_CH1_BIT] && !trig1 |=> !o_first_request_channel)
		else $error("first request not cleared by software");

	cnt_clock_a: assert property ( // RULE13
		$rose(pin_lvl[PIN_G1_L4]) |=> o_event_counter_clk)
		else $error("event counter clock does not follow line 4");

	cnt_clock_low_a: assert property ( // RULE13
		$fell(pin_lvl[PIN_G1_L4]) |=> !o_event_counter_clk)
		else $error("event counter clock missed line 4 falling");

	reset_off_a: assert property ( // RULE16
		$rose(rst_n_reg) |-> src_sel_reg == SRC_SEL_RESET && !req1_reg && !req2_reg)
		else $error("sources not disabled after reset");

	reset_line_a: assert property ( // RULE16
		$rose(rst_n_reg) |-> o_inta_n && o_event_counter_clk)
		else $error("shared line or counter clock wrong after reset");

endmodule // dual_irq_source_mux

/* testbench/irq_host_model.sv */
// bus interface controller side: turns the shared active-low line into one host level
module irq_host_model (
	// clock
	input wire logic i_core_clk,
	// shared request line from the mux
	input wire logic i_inta_n,
	// single interrupt level seen by the host
	output logic o_host_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// one level only, however many channels are pending
	always_ff @(posedge i_core_clk) begin
		o_host_irq <= ~i_inta_n;
	end
endmodule // irq_host_model

/* testbench/dual_irq_source_mux_tb.sv */
module dual_irq_source_mux_tb
	import irq_mux_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, io_wr, g1l0, g1l3, g1l4, g2l0, g2l3, evt, tmr;
	logic [7:0] io_addr, io_wdata;
	logic p1, p2, inta_n, cnt_clk, host_irq;
	int err_total = 0;
	int n_compared = 0;

	dual_irq_source_mux i_dual_irq_source_mux (.i_core_clk(clk), .i_resetn(rst_n),
		.i_io_wr(io_wr), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
		.i_grp1_ctl_line0(g1l0), .i_grp1_ctl_line3(g1l3), .i_grp1_ctl_line4(g1l4),
		.i_grp2_ctl_line0(g2l0), .i_grp2_ctl_line3(g2l3), .i_event_count_out(evt),
		.i_cascade_timer_out(tmr), .o_first_request_channel(p1),
		.o_second_request_channel(p2), .o_inta_n(inta_n), .o_event_counter_clk(cnt_clk));
	irq_host_model i_irq_host_model (.i_core_clk(clk), .i_inta_n(inta_n), .o_host_irq(host_irq));

	// clock generator, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// status byte: host level, shared line, channel 2, channel 1
	task automatic st(input logic e2, input logic e1);
		chk({4'h0, host_irq, inta_n, p2, p1}, {4'h0, e1 | e2, ~(e1 | e2), e2, e1});
	endtask

	// one-cycle write strobe, as the bus controller issues it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_wr <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clk);
		io_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// both groups driven alike; long enough for sync and latch
	task automatic lines(input logic l0, input logic l3);
		@(posedge clk);
		g1l0 <= l0;
		g2l0 <= l0;
		g1l3 <= l3;
		g2l3 <= l3;
		repeat (6) @(posedge clk);
	endtask

	task automatic close_out;
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// watchdog: the sequence needs well under 1000 cycles
	initial begin
		#20000;
		err_total++;
		close_out();
	end

	initial begin
		{rst_n, io_wr, evt} = 3'b000;
		{g1l0, g1l3, g1l4, g2l0, g2l3, tmr} = 6'h3f;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		st(0, 0);
		lines(0, 1);
		st(0, 0);
		lines(1, 1);
		// upper nibble must be ignored: both channels falling-edge mode
		wr(SRC_SEL_OFFSET, 8'hf5);
		@(posedge clk) g1l0 <= 1'b0;
		repeat (6) @(posedge clk);
		st(0, 1);
		@(posedge clk) g2l0 <= 1'b0;
		repeat (6) @(posedge clk);
		st(1, 1);
		// software sees both pending, clears one, the other holds the line
		wr(CLEAR_OFFSET, 8'h01);
		st(1, 0);
		wr(CLEAR_OFFSET, 8'h02);
		st(0, 0);
		lines(1, 1);
		st(0, 0);
		// a write elsewhere leaves the select as it was
		wr(8'h21, 8'h00);
		lines(0, 1);
		st(1, 1);
		wr(CLEAR_OFFSET, 8'h03);
		lines(1, 1);
		// combined mode on both channels
		wr(SRC_SEL_OFFSET, 8'h0a);
		lines(1, 0);
		st(0, 0);
		lines(0, 0);
		lines(1, 0);
		st(0, 0);
		lines(0, 0);
		lines(0, 1);
		st(0, 0);
		lines(0, 0);
		st(1, 1);
		wr(CLEAR_OFFSET, 8'h03);
		lines(0, 1);
		// line 0 rising together with line 3 falling must stay quiet
		lines(1, 0);
		st(0, 0);
		lines(0, 1);
		lines(1, 1);
		st(1, 1);
		wr(CLEAR_OFFSET, 8'h03);
		st(0, 0);
		// counter sources
		wr(SRC_SEL_OFFSET, 8'h0f);
		@(posedge clk) evt <= 1'b1;
		repeat (6) @(posedge clk);
		st(0, 1);
		@(posedge clk) tmr <= 1'b0;
		repeat (6) @(posedge clk);
		st(1, 1);
		wr(CLEAR_OFFSET, 8'h03);
		st(0, 0);
		// event counter clock follows group-1 line 4
		@(posedge clk) g1l4 <= 1'b0;
		repeat (4) @(posedge clk);
		chk({7'h0, cnt_clk}, 8'h00);
		@(posedge clk) g1l4 <= 1'b1;
		repeat (4) @(posedge clk);
		chk({7'h0, cnt_clk}, 8'h01);
		// disabled again: triggers are dropped
		wr(SRC_SEL_OFFSET, 8'h00);
		@(posedge clk) evt <= 1'b0;
		lines(0, 1);
		st(0, 0);
		// reset in mid-run drops pending requests and the select
		wr(SRC_SEL_OFFSET, 8'h05);
		lines(1, 1);
		lines(0, 1);
		st(1, 1);
		@(posedge clk) rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		st(0, 0);
		lines(1, 1);
		lines(0, 1);
		st(0, 0);
		close_out();
	end
endmodule // dual_irq_source_mux_tb
